// ### common/adc_misc_cfg.svh
`ifndef ADC_MISC_CFG_SVH
`define ADC_MISC_CFG_SVH
`define OFS_REF_SOURCE     8'h38
`define OFS_MARKER_INPUT   8'h3B
`define OFS_LANE_PREEMPH   8'h48
`define OFS_INPUT_ROUTING  8'h60
`define RST_REF_SOURCE     8'h00
`define RST_MARKER_INPUT   8'h00
`define RST_LANE_PREEMPH   8'h00
`define RST_INPUT_ROUTING  8'h01
`define BIT_REF_SELECT     0
`define BIT_MARKER_ON      0
`define BIT_MARKER_LVPECL  1
`define LSB_PREEMPH_LEVEL  0
`define MSB_PREEMPH_LEVEL  2
`define BIT_PREEMPH_EXTRA  3
`define BIT_DUAL_SWAP      4
`define LSB_SINGLE_SRC     0
`define MSB_SINGLE_SRC     1
`define MASK_REF_SOURCE    8'h01
`define MASK_MARKER_INPUT  8'h03
`define MASK_LANE_PREEMPH  8'h0F
`define MASK_INPUT_ROUTING 8'h13
`endif

// ### common/adc_misc_pkg.sv
package adc_misc_pkg;
   // Source choice of the single-channel field
   typedef enum logic [1:0]
   {
      SRC_RESERVED = 2'b00,
      SRC_INPUT_A  = 2'b01,
      SRC_INPUT_B  = 2'b10,
      SRC_SPLIT    = 2'b11
   } single_src_t;
endpackage

// ### hw/input_route_apply.sv
`timescale 1ns/100ps
`include "adc_misc_cfg.svh"
// Turns the routing settings into the applied channel selects
module input_route_apply
   import adc_misc_pkg::*;
(
   input  wire logic       ref_clk,        // Clock
   input  wire logic       rst,            // Sync reset
   input  wire logic       clkEn,          // Clock enable
   input  wire logic [7:0] routingReg,     // Stored routing register
   input  wire logic       singleMode,     // Link format is single-channel
   input  wire logic       calDone,        // Calibration completion pulse
   output logic            chanASelB,      // Channel A samples input B
   output logic            chanBSelA,      // Channel B samples input A
   output logic            chanAActive,    // Channel A converts
   output logic            chanBActive     // Channel B converts
);
   single_src_t srcSel;                    // Decoded single source
   logic        next_aSelB;                // Next A select
   logic        next_bSelA;                // Next B select
   logic        next_aAct;                 // Next A active
   logic        next_bAct;                 // Next B active

   assign srcSel = single_src_t'(routingReg[`MSB_SINGLE_SRC:`LSB_SINGLE_SRC]);

   // Decode the routing by link format
   always_comb
   begin
      next_aSelB = 1'b0;
      next_bSelA = 1'b0;
      next_aAct  = 1'b1;
      next_bAct  = 1'b1;
      if (singleMode)
      begin
         // Swap bit has no say here
         unique case (srcSel)
            SRC_INPUT_A:                   // Both cores on input A
            begin
               next_bSelA = 1'b1;
            end
            SRC_INPUT_B:                   // Both cores on input B
            begin
               next_aSelB = 1'b1;
            end
            SRC_SPLIT:                     // A on A, B on B
            begin
               next_aSelB = 1'b0;
            end
            SRC_RESERVED:                  // Reserved: keep A only
            begin
               next_bAct = 1'b0;
            end
         endcase
      end
      else
      begin
         // Source field has no say here
         next_aSelB = routingReg[`BIT_DUAL_SWAP];
         next_bSelA = routingReg[`BIT_DUAL_SWAP];
      end
   end

   // Apply only when calibration completes
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         chanASelB   <= 1'b0;
         chanBSelA   <= 1'b1;
         chanAActive <= 1'b1;
         chanBActive <= 1'b1;
      end
      else if (clkEn && calDone)
      begin
         chanASelB   <= next_aSelB;
         chanBSelA   <= next_bSelA;
         chanAActive <= next_aAct;
         chanBActive <= next_bAct;
      end
   end
endmodule

// ### hw/adc_misc_config_registers.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`include "adc_misc_cfg.svh"
// Miscellaneous converter configuration register bank
module adc_misc_config_registers
   import adc_misc_pkg::*;
#(
   parameter int LANES = 16                // Serial output lanes
)
(
   input  wire logic             ref_clk,            // 125 MHz clock
   input  wire logic             rst,                // Sync reset, high
   input  wire logic             clkEn,              // Clock enable
   input  wire logic [7:0]       regAddr,            // Register address
   input  wire logic [7:0]       regWrData,          // Write data
   input  wire logic             regWrStb,           // Write strobe
   input  wire logic             regRdStb,           // Read strobe
   output logic      [7:0]       regRdData,          // Read data, next cycle
   input  wire logic             singleMode,         // Link format single-channel
   input  wire logic             calDone,            // Calibration done pulse
   output logic                  refSourceSelect,    // Reference from core supply
   output logic                  markerReceiverOn,   // Marker receiver enable
   output logic                  markerLvpeclSelect, // Marker LVPECL mode
   output logic [LANES*3-1:0]    lanePreemphLevel,   // Level per lane
   output logic [LANES-1:0]      lanePreemphExtra,   // Boost per lane
   output logic                  chanASelB,          // Channel A on input B
   output logic                  chanBSelA,          // Channel B on input A
   output logic                  chanAActive,        // Channel A converts
   output logic                  chanBActive         // Channel B converts
);
   logic [7:0] refSourceReg;               // Reference control
   logic [7:0] markerReg;                  // Marker control
   logic [7:0] preemphReg;                 // Serializer control
   logic [7:0] routingReg;                 // Input routing

   // Elaboration check: at least one lane must exist
   generate
      if (LANES < 1)
      begin : gBadLanes
         $error("LANES must be at least one");
      end
   endgenerate

   // Address match helper
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Reference control register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         refSourceReg <= `RST_REF_SOURCE;
      else if (clkEn && regWrStb && hit(regAddr, `OFS_REF_SOURCE))
         refSourceReg <= regWrData;
   end

   // Marker control register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         markerReg <= `RST_MARKER_INPUT;
      else if (clkEn && regWrStb && hit(regAddr, `OFS_MARKER_INPUT))
         markerReg <= regWrData;
   end

   // Serializer pre-emphasis register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         preemphReg <= `RST_LANE_PREEMPH;
      else if (clkEn && regWrStb && hit(regAddr, `OFS_LANE_PREEMPH))
         preemphReg <= regWrData;
   end

   // Input routing register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         routingReg <= `RST_INPUT_ROUTING;
      else if (clkEn && regWrStb && hit(regAddr, `OFS_INPUT_ROUTING))
         routingReg <= regWrData;
   end

   // Read port, one cycle latency; unmapped reads zero
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         regRdData <= 8'h00;
      else if (clkEn)
      begin
         if (!regRdStb)
            regRdData <= 8'h00;
         else if (hit(regAddr, `OFS_REF_SOURCE))
            regRdData <= refSourceReg;
         else if (hit(regAddr, `OFS_MARKER_INPUT))
            regRdData <= markerReg;
         else if (hit(regAddr, `OFS_LANE_PREEMPH))
            regRdData <= preemphReg;
         else if (hit(regAddr, `OFS_INPUT_ROUTING))
            regRdData <= routingReg;
         else
            regRdData <= 8'h00;
      end
   end

   // Reference and marker controls
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         refSourceSelect    <= 1'b0;
         markerReceiverOn   <= 1'b0;
         markerLvpeclSelect <= 1'b0;
      end
      else if (clkEn)
      begin
         refSourceSelect    <= refSourceReg[`BIT_REF_SELECT];
         markerReceiverOn   <= markerReg[`BIT_MARKER_ON];
         markerLvpeclSelect <= markerReg[`BIT_MARKER_LVPECL];
      end
   end

   // One common setting fanned to every lane
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : gLane
         always_ff @(posedge ref_clk)
         begin
            if (rst)
            begin
               lanePreemphLevel[g*3 +: 3] <= 3'h0;
               lanePreemphExtra[g]        <= 1'b0;
            end
            else if (clkEn)
            begin
               lanePreemphLevel[g*3 +: 3] <=
                  preemphReg[`MSB_PREEMPH_LEVEL:`LSB_PREEMPH_LEVEL];
               lanePreemphExtra[g] <= preemphReg[`BIT_PREEMPH_EXTRA];
            end
         end
      end
   endgenerate

   // Routing applied at calibration completion
   input_route_apply uRoute
   (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .clkEn       (clkEn),
      .routingReg  (routingReg),
      .singleMode  (singleMode),
      .calDone     (calDone),
      .chanASelB   (chanASelB),
      .chanBSelA   (chanBSelA),
      .chanAActive (chanAActive),
      .chanBActive (chanBActive)
   );
endmodule

// ### bench/adc_misc_config_registers_sva.sv
`timescale 1ns/100ps
// Ties bank outputs to accepted bus writes and calibration pulses
module adc_misc_config_registers_sva
#(
   parameter int LANES = 16 // Lane count
)
(
   input wire logic               ref_clk, // Clock
   input wire logic               rst, // Sync reset
   input wire logic               clkEn, // Clock enable
   input wire logic [7:0]         regAddr, // Address
   input wire logic [7:0]         regWrData, // Write data
   input wire logic               regWrStb, // Write strobe
   input wire logic               regRdStb, // Read strobe
   input wire logic [7:0]         regRdData, // Read data
   input wire logic               singleMode, // Single-channel format
   input wire logic               calDone, // Calibration end
   input wire logic               refSourceSelect, // Reference choice
   input wire logic               markerReceiverOn, // Marker enable
   input wire logic               markerLvpeclSelect, // Marker mode
   input wire logic [LANES*3-1:0] lanePreemphLevel, // Lane levels
   input wire logic [LANES-1:0]   lanePreemphExtra, // Lane boosts
   input wire logic               chanASelB, // A on input B
   input wire logic               chanBSelA, // B on input A
   input wire logic               chanAActive, // A converts
   input wire logic               chanBActive // B converts
);
   logic [7:0] route; // Shadow of the routing register
   // Shadow follows accepted routing writes
   always_ff @(posedge ref_clk)
      if (rst)
         route <= 8'h01;
      else if (clkEn && regWrStb && regAddr == 8'h60)
         route <= regWrData;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Accepted write, then one enabled cycle
   sequence s_wr(a); clkEn && regWrStb && regAddr == a ##1 clkEn; endsequence
   // Accepted calibration pulse
   sequence s_cal; clkEn && calDone; endsequence
   property p_ref; s_wr(8'h38) |=> refSourceSelect == $past(regWrData[0], 2); endproperty
   a_ref: assert property (p_ref) else $error("reference select wrong");
   property p_lvp; s_wr(8'h3B) |=> markerLvpeclSelect == $past(regWrData[1], 2); endproperty
   a_lvp: assert property (p_lvp) else $error("marker mode wrong");
   property p_on; s_wr(8'h3B) |=> markerReceiverOn == $past(regWrData[0], 2); endproperty
   a_on: assert property (p_on) else $error("marker enable wrong");
   property p_lvl; s_wr(8'h48) |=> lanePreemphLevel == {LANES{$past(regWrData[2:0], 2)}}; endproperty
   a_lvl: assert property (p_lvl) else $error("lane level wrong");
   property p_ext; s_wr(8'h48) |=> lanePreemphExtra == {LANES{$past(regWrData[3], 2)}}; endproperty
   a_ext: assert property (p_ext) else $error("lane boost wrong");
   property p_rst; $fell(rst) |-> !refSourceSelect && !markerReceiverOn && chanBSelA &&
      !chanASelB && chanAActive && chanBActive && lanePreemphLevel == '0; endproperty
   a_rst: assert property (p_rst) else $error("reset outputs wrong");
   property p_dual; s_cal ##0 !singleMode |=> chanASelB == $past(route[4]) &&
      chanBSelA == $past(route[4]) && chanAActive && chanBActive; endproperty
   a_dual: assert property (p_dual) else $error("dual routing wrong");
   property p_sgl; s_cal ##0 singleMode |=> chanASelB == ($past(route[1:0]) == 2'h2) &&
      chanBSelA == ($past(route[1:0]) == 2'h1) && chanBActive == ($past(route[1:0]) != 2'h0);
   endproperty
   a_sgl: assert property (p_sgl) else $error("single routing wrong");
   property p_hold; !(clkEn && calDone) |=>
      $stable({chanASelB, chanBSelA, chanAActive, chanBActive}); endproperty
   a_hold: assert property (p_hold) else $error("routing moved early");
   property p_rdroute; clkEn && regRdStb && regAddr == 8'h60 |=> regRdData == $past(route);
   endproperty
   a_rdroute: assert property (p_rdroute) else $error("routing readback wrong");
endmodule
bind adc_misc_config_registers adc_misc_config_registers_sva #(.LANES(LANES)) i_sva (
   .ref_clk, .rst, .clkEn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
   .singleMode, .calDone,
   .refSourceSelect, .markerReceiverOn, .markerLvpeclSelect, .lanePreemphLevel,
   .lanePreemphExtra, .chanASelB, .chanBSelA, .chanAActive, .chanBActive);

// ### bench/testbench.sv
`timescale 1ns/100ps
// Compares a value with its expectation and counts the outcome
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) \
   begin nMismatch++; $display("CHECK FAILED %0t got %h", $time, g); end end
module testbench;
   logic        ref_clk = 1'b0; // Clock
   logic        rst = 1'b1; // Reset
   logic        clkEn = 1'b1; // Enable
   logic [7:0]  regAddr = 8'h00; // Address
   logic [7:0]  regWrData = 8'h00; // Write data
   logic        regWrStb = 1'b0; // Write strobe
   logic        regRdStb = 1'b0; // Read strobe
   logic        singleMode = 1'b0; // Format
   logic        calDone = 1'b0; // Calibration end
   logic [7:0]  regRdData; // Read data
   logic        refSourceSelect, markerReceiverOn, markerLvpeclSelect; // Controls
   logic [47:0] lanePreemphLevel; // Lane levels
   logic [15:0] lanePreemphExtra; // Lane boosts
   logic        chanASelB, chanBSelA, chanAActive, chanBActive; // Routing
   int          nMismatch = 0; // Failed checks
   int          comparisons = 0; // Checks made
   int          i; // Loop index
   logic [7:0]  v; // Routing value
   logic [3:0]  prev; // Expected routing outputs
   wire logic [3:0] routeOut = {chanASelB, chanBSelA, chanAActive, chanBActive}; // Routing
   initial forever #4 ref_clk = ~ref_clk;
   adc_misc_config_registers #(.LANES(16)) i_adc_misc_config_registers (
      .ref_clk, .rst, .clkEn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
      .singleMode, .calDone, .refSourceSelect, .markerReceiverOn, .markerLvpeclSelect,
      .lanePreemphLevel, .lanePreemphExtra, .chanASelB, .chanBSelA, .chanAActive,
      .chanBActive);
   // One strobe cycle of any kind
   task automatic bus(input logic [7:0] a, d, input logic w, r, c);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= w;
      regRdStb <= r;
      calDone <= c;
      @(posedge ref_clk);
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
      calDone <= 1'b0;
      #1;
   endtask
   // Write, then wait until the controls follow
   task automatic wr(input logic [7:0] a, d);
      bus(a, d, 1'b1, 1'b0, 1'b0);
      @(posedge ref_clk);
      #1;
   endtask
   // Read and compare in the answer cycle
   task automatic rd(input logic [7:0] a, e);
      bus(a, 8'h00, 1'b0, 1'b1, 1'b0);
      `CHK(regRdData, e)
      @(posedge ref_clk);
      #1;
      `CHK(regRdData, 8'h00) // Read data stands one cycle only
   endtask
   // Report and stop
   task conclude;
      $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
      if (nMismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      nMismatch++;
      conclude();
   end
   // Main sequence
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      `CHK(routeOut, 4'h7)
      rd(8'h38, 8'h00);
      rd(8'h3B, 8'h00);
      rd(8'h48, 8'h00);
      rd(8'h60, 8'h01);
      rd(8'h39, 8'h00); // Unmapped place
      for (i = 0; i < 4; i++)
      begin
         wr(8'h38, {7'h00, i[0]});
         `CHK(refSourceSelect, i[0])
         wr(8'h3B, i[7:0]);
         `CHK(markerReceiverOn, i[0])
         `CHK(markerLvpeclSelect, i[1])
      end
      for (i = 0; i < 16; i++)
      begin
         wr(8'h48, i[7:0]);
         `CHK(lanePreemphLevel, {16{i[2:0]}})
         `CHK(lanePreemphExtra, {16{i[3]}})
      end
      clkEn <= 1'b0;
      wr(8'h48, 8'h05);
      clkEn <= 1'b1;
      rd(8'h48, 8'h0F); // Frozen write ignored
      prev = 4'h7;
      for (i = 0; i < 16; i++)
      begin
         v = {3'h0, i[2], 2'h0, i[1:0]};
         singleMode <= i[3];
         wr(8'h60, v);
         `CHK(routeOut, prev)
         bus(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
         if (i[3])
            prev = {v[1:0] == 2'h2, v[1:0] == 2'h1, 1'b1, v[1:0] != 2'h0};
         else
            prev = {v[4], v[4], 2'h3};
         `CHK(routeOut, prev)
      end
      conclude();
   end
endmodule
